//--- hdl/sgi_map.vh
// Purpose: constants for the global ingress rules register bank
// Assumes: included by bare name from the design file
// Notes:   register indices are kept; byte address is four times the index
`ifndef SGI_MAP_VH
`define SGI_MAP_VH

// register indices
`define SGI_IDX_DS_CMD   14'h1811
`define SGI_IDX_DS_WR    14'h1812
`define SGI_IDX_DS_RD    14'h1813
`define SGI_IDX_DS_STS   14'h1814
`define SGI_IDX_CFG      14'h1840

// byte addresses on the bus
`define SGI_A_DS_CMD     ({`SGI_IDX_DS_CMD, 2'b00})
`define SGI_A_DS_WR      ({`SGI_IDX_DS_WR, 2'b00})
`define SGI_A_DS_RD      ({`SGI_IDX_DS_RD, 2'b00})
`define SGI_A_DS_STS     ({`SGI_IDX_DS_STS, 2'b00})
`define SGI_A_CFG        ({`SGI_IDX_CFG, 2'b00})

// global ingress configuration fields
`define SGI_CFG_W        18
`define SGI_CFG_RST      18'h00006
`define SGI_B_NH_OTHER   17
`define SGI_B_HBH_ANY    16
`define SGI_B_VID_DIS    15
`define SGI_B_USE_TAG    14
`define SGI_B_MON_ECHO   13
`define SGI_F_MON_HI     12
`define SGI_F_MON_LO     10
`define SGI_B_USE_IP     9
`define SGI_B_MLD_EN     8
`define SGI_B_IGMP_EN    7
`define SGI_B_CNT_TEST   6
`define SGI_B_DA_HI      5
`define SGI_B_FLT_MC     4
`define SGI_B_DROP_UNK   3
`define SGI_B_USE_PREC   2
`define SGI_B_VL_HI      1
`define SGI_B_VLAN_EN    0

// table command fields
`define SGI_B_DS_RNW     7
`define SGI_F_DS_IDX_HI  5
`define SGI_F_DS_IDX_LO  0
`define SGI_B_DS_PEND    0

// counter value loaded on read while counter test is on
`define SGI_CNT_TEST_VAL 32'h7ffffffc
`define SGI_CNT_ZERO     32'h00000000

// count loaded by a table command; pending stays up one cycle longer, four cycles in all
`define SGI_DS_OP_CYC    2'd3

// protocol codes
`define SGI_PROTO_IGMP   8'h02
`define SGI_NH_HBH       8'h00
`define SGI_NH_ICMP6     8'h3a
`define SGI_NH_ROUTE     8'h2b
`define SGI_NH_FRAG      8'h2c
`define SGI_NH_ESP       8'h32
`define SGI_NH_AH        8'h33
`define SGI_NH_DEST      8'h3c

`endif

//--- hdl/sgi_ingress_rules.v
// Purpose: global ingress rule registers, table command engine and
//          per-packet classification driven by them
// Assumes: packet inputs come from logic on i_ref_clk; AHB-Lite slave
// Notes:   result appears one cycle after i_pkt_valid
`timescale 1ns/10ps
`default_nettype none
`include "sgi_map.vh"

module sgi_ingress_rules (
   input  wire        i_ref_clk,
   input  wire        i_rst,
   input  wire        i_hsel,
   input  wire [15:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hready,
   output wire [31:0] o_hrdata,
   output wire        o_hreadyout,
   output wire        o_hresp,
   input  wire        i_pkt_valid,
   input  wire [1:0]  i_src_port,
   input  wire [11:0] i_port_vid,
   input  wire [2:0]  i_port_pri,
   input  wire        i_tagged,
   input  wire [11:0] i_tag_vid,
   input  wire [2:0]  i_tag_pri,
   input  wire        i_ipv4,
   input  wire        i_ipv6,
   input  wire [7:0]  i_tos,
   input  wire [7:0]  i_ip_proto,
   input  wire [7:0]  i_hbh_nh,
   input  wire        i_mld_icmp,
   input  wire        i_da_mcast,
   input  wire        i_da_bcast,
   input  wire        i_lut_hit,
   input  wire        i_lut_pri_en,
   input  wire [2:0]  i_lut_pri,
   input  wire [2:0]  i_fwd_mask,
   output wire        o_res_valid,
   output wire [11:0] o_res_vid,
   output wire        o_res_vlan_en,
   output wire [2:0]  o_res_pri,
   output wire [2:0]  o_res_mask,
   output wire        o_res_drop,
   output wire        o_res_snoop,
   output wire        o_cnt_test,
   output wire [31:0] o_cnt_rd_val
);

   // command engine states
   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_BUSY = 1'b1;

   // bus state
   reg                  wr_q;
   reg  [15:0]          wa_q;
   reg                  rd_q;
   reg  [15:0]          ra_q;
   reg                  hready_q;
   reg  [31:0]          hrdata_q;

   // software visible state and the command cycle count
   reg  [`SGI_CFG_W-1:0] cfg_q;
   reg                  ds_rnw_q;
   reg  [5:0]           ds_idx_q;
   reg  [2:0]           ds_wr_q;
   reg  [2:0]           ds_rd_q;
   reg                  st_q;
   reg  [1:0]           cnt_q;

   // table storage, never reset
   // an entry never written gives an unknown priority; fill all 64 first
   reg  [2:0]           ds_tbl [0:63];

   // result registers
   reg                  rv_q;
   reg  [11:0]          vid_q;
   reg                  ven_q;
   reg  [2:0]           pri_q;
   reg  [2:0]           mask_q;
   reg                  drop_q;
   reg                  snp_q;
   reg  [31:0]          crv_q;

   wire                 acc;
   wire                 cmd_wr;
   wire                 done;
   reg  [31:0]          rmux;

   // a transfer is taken when selected, non-idle and the bus is ready
   // a second request cannot arrive while a read is waiting: hready is low
   assign acc = i_hsel & i_htrans[1] & i_hready;

   // bus slave: writes land in their data phase, reads add one wait
   // state so a read right after a write sees the written value
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_q     <= 1'b0;
         wa_q     <= 16'h0000;
         rd_q     <= 1'b0;
         ra_q     <= 16'h0000;
         hready_q <= 1'b1;
         hrdata_q <= 32'h00000000;
      end else begin
         wr_q <= 1'b0;
         if (rd_q) begin
            rd_q     <= 1'b0;
            hready_q <= 1'b1;
            hrdata_q <= rmux;
         end else if (acc) begin
            wr_q     <= i_hwrite;
            wa_q     <= i_haddr;
            rd_q     <= ~i_hwrite;
            ra_q     <= i_haddr;
            hready_q <= i_hwrite;
         end
      end
   end

   // read mux; unmapped and reserved bits read as zero
   // decoded from the registered address so the wait state hides the mux
   always @* begin
      rmux = 32'h00000000;
      case (ra_q)
         `SGI_A_CFG: begin
            rmux[`SGI_CFG_W-1:0] = cfg_q;
         end
         `SGI_A_DS_CMD: begin
            rmux[`SGI_B_DS_RNW] = ds_rnw_q;
            rmux[`SGI_F_DS_IDX_HI:`SGI_F_DS_IDX_LO] = ds_idx_q;
         end
         `SGI_A_DS_WR: begin
            rmux[2:0] = ds_wr_q;
         end
         `SGI_A_DS_RD: begin
            rmux[2:0] = ds_rd_q;
         end
         `SGI_A_DS_STS: begin
            rmux[`SGI_B_DS_PEND] = st_q;
         end
         default: begin
            rmux = 32'h00000000;
         end
      endcase
   end

   // command write starts an access unless one is already running
   assign cmd_wr = wr_q & (wa_q == `SGI_A_DS_CMD) & (st_q == ST_IDLE);
   assign done   = (st_q == ST_BUSY) & (cnt_q == 2'd0);

   // configuration and table staging registers
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         cfg_q    <= `SGI_CFG_RST;
         ds_rnw_q <= 1'b0;
         ds_idx_q <= 6'h00;
         ds_wr_q  <= 3'h0;
      end else if (wr_q) begin
         if (wa_q == `SGI_A_CFG) begin
            cfg_q <= i_hwdata[`SGI_CFG_W-1:0];
         end
         if (wa_q == `SGI_A_DS_WR) begin
            ds_wr_q <= i_hwdata[2:0];
         end
         if (cmd_wr) begin
            ds_rnw_q <= i_hwdata[`SGI_B_DS_RNW];
            ds_idx_q <= i_hwdata[`SGI_F_DS_IDX_HI:`SGI_F_DS_IDX_LO];
         end
      end
   end

   // command engine: pending stays up for a fixed number of cycles and
   // drops by itself; status is read-only so software cannot clear it
   // a command written while busy is dropped, so software polls first
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_q  <= ST_IDLE;
         cnt_q <= 2'd0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (cmd_wr) begin
                  st_q  <= ST_BUSY;
                  cnt_q <= `SGI_DS_OP_CYC;
               end
            end
            ST_BUSY: begin
               if (done) begin
                  st_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 2'd1;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // table access at the end of the command; write data is taken then
   always @(posedge i_ref_clk) begin
      if (done & ~ds_rnw_q) begin
         ds_tbl[ds_idx_q] <= ds_wr_q;
      end
   end

   // read result register
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         ds_rd_q <= 3'h0;
      end else if (done & ds_rnw_q) begin
         ds_rd_q <= ds_tbl[ds_idx_q];
      end
   end

   // ---- packet classification ----
   wire [2:0] src_oh;
   wire [2:0] mon_map;
   wire       ext_nh;
   wire       ext_hbh;
   wire       nh_ok;
   wire       is_mld;
   wire       is_igmp;
   wire       snoop;
   wire       has_ip;
   wire       tag_ok;
   wire       ip_ok;
   wire [2:0] ip_pri;
   wire       unk_uc;
   wire       unk_mc;
   reg  [2:0] pri_d;

   assign src_oh  = 3'b001 << i_src_port;
   assign mon_map = cfg_q[`SGI_F_MON_HI:`SGI_F_MON_LO];

   // other extension headers count only with bit 17
   assign ext_nh  = cfg_q[`SGI_B_NH_OTHER] &
                    ((i_ip_proto == `SGI_NH_ROUTE) | (i_ip_proto == `SGI_NH_FRAG) |
                     (i_ip_proto == `SGI_NH_ESP) | (i_ip_proto == `SGI_NH_AH) |
                     (i_ip_proto == `SGI_NH_DEST));
   assign ext_hbh = cfg_q[`SGI_B_NH_OTHER] &
                    ((i_hbh_nh == `SGI_NH_ROUTE) | (i_hbh_nh == `SGI_NH_FRAG) |
                     (i_hbh_nh == `SGI_NH_ESP) | (i_hbh_nh == `SGI_NH_AH) |
                     (i_hbh_nh == `SGI_NH_DEST));

   // hop-by-hop next header is don't-care with bit 16
   assign nh_ok = (i_ip_proto == `SGI_NH_ICMP6) | ext_nh |
                  ((i_ip_proto == `SGI_NH_HBH) &
                   (cfg_q[`SGI_B_HBH_ANY] | (i_hbh_nh == `SGI_NH_ICMP6) |
                    ext_hbh));

   assign is_mld  = cfg_q[`SGI_B_MLD_EN] & i_ipv6 & i_mld_icmp & nh_ok;
   assign is_igmp = cfg_q[`SGI_B_IGMP_EN] & i_ipv4 &
                    (i_ip_proto == `SGI_PROTO_IGMP);
   assign snoop   = is_mld | is_igmp;

   // priority candidates
   assign has_ip = i_ipv4 | i_ipv6;
   assign tag_ok = cfg_q[`SGI_B_USE_TAG] & i_tagged;
   assign ip_ok  = cfg_q[`SGI_B_USE_IP] & has_ip;
   // IPv4 picks precedence or table; IPv6 uses the class precedence bits
   assign ip_pri = (i_ipv4 & ~cfg_q[`SGI_B_USE_PREC]) ?
                   ds_tbl[i_tos[7:2]] : i_tos[7:5];

   // priority selection: address table first, then tag/IP, else port
   // bit 1 only breaks the tie when tag and IP are both usable
   always @* begin
      pri_d = i_port_pri;
      if (cfg_q[`SGI_B_DA_HI] & i_lut_hit & i_lut_pri_en) begin
         pri_d = i_lut_pri;
      end else if (tag_ok & ip_ok) begin
         pri_d = cfg_q[`SGI_B_VL_HI] ? i_tag_pri : ip_pri;
      end else if (tag_ok) begin
         pri_d = i_tag_pri;
      end else if (ip_ok) begin
         pri_d = ip_pri;
      end
   end

   // filtering of unknown destinations; broadcast is exempt
   assign unk_uc = cfg_q[`SGI_B_DROP_UNK] & ~i_da_mcast & ~i_lut_hit;
   assign unk_mc = cfg_q[`SGI_B_FLT_MC] & i_da_mcast & ~i_da_bcast &
                   ~i_lut_hit;

   // result register; snooped packets are never dropped by the filters
   // only valid is a pulse; the other results hold until the next packet
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         rv_q   <= 1'b0;
         vid_q  <= 12'h000;
         ven_q  <= 1'b0;
         pri_q  <= 3'h0;
         mask_q <= 3'h0;
         drop_q <= 1'b0;
         snp_q  <= 1'b0;
      end else begin
         rv_q <= i_pkt_valid;
         if (i_pkt_valid) begin
            // VID for rule checks only; the egress tag is not touched
            vid_q <= (cfg_q[`SGI_B_VID_DIS] | ~i_tagged) ?
                     i_port_vid : i_tag_vid;
            ven_q <= cfg_q[`SGI_B_VLAN_EN];
            pri_q <= pri_d;
            snp_q <= snoop;
            if (snoop) begin
               mask_q <= cfg_q[`SGI_B_MON_ECHO] ? mon_map :
                         (mon_map & ~src_oh);
               drop_q <= 1'b0;
            end else begin
               mask_q <= i_fwd_mask & ~src_oh;
               drop_q <= unk_uc | unk_mc;
            end
         end
      end
   end

   // counter test: tell the counters what a read leaves behind
   // one cycle behind a config write; the counters live outside this block
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         crv_q <= `SGI_CNT_ZERO;
      end else begin
         crv_q <= cfg_q[`SGI_B_CNT_TEST] ? `SGI_CNT_TEST_VAL :
                  `SGI_CNT_ZERO;
      end
   end

   // outputs straight from flops
   // hresp is tied to OKAY: no transfer here can fail or need a retry
   assign o_hrdata      = hrdata_q;
   assign o_hreadyout   = hready_q;
   assign o_hresp       = 1'b0;     // always OKAY
   assign o_res_valid   = rv_q;
   assign o_res_vid     = vid_q;
   assign o_res_vlan_en = ven_q;
   assign o_res_pri     = pri_q;
   assign o_res_mask    = mask_q;
   assign o_res_drop    = drop_q;
   assign o_res_snoop   = snp_q;
   assign o_cnt_test    = cfg_q[`SGI_B_CNT_TEST];
   assign o_cnt_rd_val  = crv_q;

   // hsize is unused: only whole-word transfers are supported
   // a narrower write still updates the whole register
   wire unused_ok = &{1'b0, i_hsize};

endmodule // sgi_ingress_rules

`default_nettype wire

//--- bench/sgi_monitor.sv
// Purpose: temporal checks on the global ingress rules block
// Assumes: one slave, writes complete without wait states
// Notes:   config is mirrored from bus writes seen at the ports
`timescale 1ns/10ps
`default_nettype none
module sgi_monitor (
   input wire logic        i_ref_clk,
   input wire logic        i_rst,
   input wire logic        i_hsel,
   input wire logic [15:0] i_haddr,
   input wire logic [1:0]  i_htrans,
   input wire logic        i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic        i_hready,
   input wire logic        o_hreadyout,
   input wire logic        i_pkt_valid,
   input wire logic [1:0]  i_src_port,
   input wire logic [2:0]  i_port_pri,
   input wire logic        i_ipv4,
   input wire logic        i_ipv6,
   input wire logic [7:0]  i_ip_proto,
   input wire logic        i_da_mcast,
   input wire logic        i_da_bcast,
   input wire logic        i_lut_hit,
   input wire logic        i_lut_pri_en,
   input wire logic [2:0]  i_lut_pri,
   input wire logic [2:0]  o_res_pri,
   input wire logic [2:0]  o_res_mask,
   input wire logic        o_res_drop,
   input wire logic        o_res_snoop,
   input wire logic [31:0] o_cnt_rd_val
);
   logic [17:0] cfg_q;
   logic        wr_q;
   logic [15:0] ad_q;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // shadow of the config; updates on the same edge as the block's own copy
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         cfg_q <= 18'h00006;
         wr_q  <= 1'b0;
      end else if (i_hready) begin
         wr_q <= i_hsel & i_htrans[1] & i_hwrite;
         ad_q <= i_haddr;
         if (wr_q && ad_q == 16'h6100) cfg_q <= i_hwdata[17:0];
      end
   end
   sequence s_rd_take;
      i_hsel && i_htrans[1] && !i_hwrite && i_hready;
   endsequence
   sequence s_rd_wait;
      !o_hreadyout ##1 o_hreadyout;
   endsequence
   a_read_wait: assert property (s_rd_take |=> s_rd_wait)
      else $error("read wait state wrong");
   a_cnt_value: assert property ($stable(cfg_q[6]) [*3] |->
      o_cnt_rd_val == (cfg_q[6] ? 32'h7ffffffc : 32'h0)) else $error("counter load value");
   a_uc_drop: assert property (i_pkt_valid && cfg_q[3] && !i_ipv4 && !i_ipv6
      && !i_da_mcast && !i_lut_hit |=> o_res_drop) else $error("unknown unicast kept");
   a_mc_drop: assert property (i_pkt_valid && cfg_q[4] && !i_ipv4 && !i_ipv6
      && i_da_mcast && !i_lut_hit |=> o_res_drop != $past(i_da_bcast))
      else $error("multicast filter wrong");
   a_no_echo: assert property (i_pkt_valid && !cfg_q[13]
      |=> !o_res_mask[$past(i_src_port)]) else $error("sent back to source");
   a_da_pri: assert property (i_pkt_valid && cfg_q[5] && i_lut_hit && i_lut_pri_en
      |=> o_res_pri == $past(i_lut_pri)) else $error("table priority not used");
   a_port_pri: assert property (i_pkt_valid && !cfg_q[5] && !cfg_q[14] && !cfg_q[9]
      |=> o_res_pri == $past(i_port_pri)) else $error("port priority not used");
   a_igmp_mon: assert property (i_pkt_valid && cfg_q[7] && cfg_q[13] && i_ipv4
      && i_ip_proto == 8'h02 |=> o_res_snoop && !o_res_drop
      && o_res_mask == $past(cfg_q[12:10])) else $error("igmp not snooped");
endmodule // sgi_monitor
bind sgi_ingress_rules sgi_monitor sgi_monitor_i (.*);
`default_nettype wire

//--- bench/testbench.sv
// Purpose: random and corner tests of the global ingress rules block
// Assumes: single AHB-Lite slave, hready looped back
// Notes:   table is filled first so expected priorities are never unknown
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        i_ref_clk, i_rst, i_hsel, i_hwrite, i_pkt_valid, i_tagged, i_ipv4, i_ipv6;
   logic        i_mld_icmp, i_da_mcast, i_da_bcast, i_lut_hit, i_lut_pri_en;
   logic [1:0]  i_htrans, i_src_port;
   logic [2:0]  i_hsize, i_port_pri, i_tag_pri, i_lut_pri, i_fwd_mask;
   logic [7:0]  i_tos, i_ip_proto, i_hbh_nh;
   logic [11:0] i_port_vid, i_tag_vid;
   logic [15:0] i_haddr, rn;
   logic [31:0] i_hwdata, q, r, s;
   logic [17:0] cfg;
   logic [2:0]  ds [0:63];
   wire         i_hready, o_hreadyout, o_hresp, o_res_valid, o_res_vlan_en;
   wire         o_res_drop, o_res_snoop, o_cnt_test;
   wire  [2:0]  o_res_pri, o_res_mask;
   wire  [11:0] o_res_vid;
   wire  [31:0] o_hrdata, o_cnt_rd_val;
   int          n_mismatch, n_compared, i, j;
   // next header codes drawn for packets: hop-by-hop, ICMPv6, extensions, UDP
   function logic [7:0] nh(input logic [2:0] k);
      case (k)
         3'd0: nh = 8'h00;
         3'd1: nh = 8'h3a;
         3'd2: nh = 8'h2b;
         3'd3: nh = 8'h2c;
         3'd4: nh = 8'h32;
         3'd5: nh = 8'h33;
         3'd6: nh = 8'h3c;
         default: nh = 8'h11;
      endcase
   endfunction
   assign i_hready = o_hreadyout; // only slave on the bus
   sgi_ingress_rules sgi_ingress_rules_i (.*);
   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function logic [15:0] lf(input logic [15:0] v);
      lf = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task rnd(output logic [31:0] v);
      repeat (32) begin
         rn = lf(rn);
         v = {v[30:0], rn[0]};
      end
   endtask
   // master holds each phase until hready is sampled high
   task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_hsel <= 1'b1;
      i_htrans <= 2'b10;
      i_hwrite <= w;
      i_haddr <= a;
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'b00;
      i_hwdata <= d;
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      q = o_hrdata;
      chk("hresp", {31'h0, o_hresp}, 32'h0);
   endtask
   function logic ext(input logic [7:0] x);
      ext = (x == 8'h2b) | (x == 8'h2c) | (x == 8'h32) | (x == 8'h33) | (x == 8'h3c);
   endfunction
   // expected {vid, pri, mask, drop, snoop} for the packet now on the inputs
   function logic [19:0] model(input logic [17:0] c);
      logic tg, ipe, mld, sn;
      logic [2:0] ipp, pri, src, msk;
      tg = c[14] & i_tagged;
      ipe = c[9] & (i_ipv4 | i_ipv6);
      ipp = (i_ipv4 & !c[2]) ? ds[i_tos[7:2]] : i_tos[7:5];
      pri = (c[5] & i_lut_hit & i_lut_pri_en) ? i_lut_pri : (tg & ipe) ? (c[1] ? i_tag_pri : ipp)
         : tg ? i_tag_pri : ipe ? ipp : i_port_pri;
      mld = c[8] & i_ipv6 & i_mld_icmp & (i_ip_proto == 8'h3a | c[17] & ext(i_ip_proto)
         | i_ip_proto == 8'h00 & (c[16] | i_hbh_nh == 8'h3a | c[17] & ext(i_hbh_nh)));
      sn = c[7] & i_ipv4 & i_ip_proto == 8'h02 | mld;
      src = 3'b001 << i_src_port;
      msk = sn ? c[12:10] & ~(c[13] ? 3'b000 : src) : i_fwd_mask & ~src;
      model = {(c[15] | !i_tagged) ? i_port_vid : i_tag_vid, pri, msk,
         !sn & (c[3] & !i_da_mcast & !i_lut_hit | c[4] & i_da_mcast & !i_da_bcast & !i_lut_hit),
         sn};
   endfunction
   task pkt;
      logic [19:0] e;
      rnd(r);
      rnd(s);
      @(posedge i_ref_clk);
      i_pkt_valid <= 1'b1;
      i_src_port <= (r[1:0] == 2'd3) ? 2'd2 : r[1:0];
      i_tagged <= r[2];
      i_ipv4 <= r[3];
      i_ipv6 <= r[4] & !r[3];
      i_tos <= r[12:5];
      i_ip_proto <= r[13] ? 8'h02 : nh(r[16:14]);
      i_hbh_nh <= nh(r[19:17]);
      i_mld_icmp <= r[20];
      i_da_mcast <= r[21];
      i_da_bcast <= r[21] & r[22];
      i_lut_hit <= r[23];
      i_lut_pri_en <= r[24];
      i_lut_pri <= r[27:25];
      i_port_pri <= r[30:28];
      i_fwd_mask <= s[2:0];
      i_tag_pri <= s[5:3];
      i_port_vid <= s[17:6];
      i_tag_vid <= s[29:18];
      #1 e = model(cfg);
      @(posedge i_ref_clk);
      i_pkt_valid <= 1'b0;
      #1 chk("res_valid", o_res_valid, 32'h1);
      chk("res_pri", o_res_pri, e[7:5]);
      chk("res_vid", o_res_vid, e[19:8]);
      chk("res_vlan_en", o_res_vlan_en, cfg[0]);
      chk("res_mask", o_res_mask, e[4:2]);
      chk("res_drop_snoop", {o_res_drop, o_res_snoop}, e[1:0]);
   endtask
   task wrap_up;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {i_hsel, i_hwrite, i_pkt_valid, i_tagged, i_ipv4, i_ipv6, i_mld_icmp, i_da_mcast,
         i_da_bcast, i_lut_hit, i_lut_pri_en, i_htrans, i_src_port, i_port_pri, i_tag_pri,
         i_lut_pri, i_fwd_mask, i_tos, i_ip_proto, i_hbh_nh, i_port_vid, i_tag_vid, i_haddr,
         i_hwdata} = '0;
      i_hsize = 3'b010;
      rn = 16'hef28;
      i_rst = 1'b1;
      repeat (10) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      bus(0, 16'h6100, 0);
      chk("cfg_reset", q, 32'h6);
      bus(1, 16'h6050, 32'h1);
      bus(0, 16'h6050, 0);
      chk("pend_ro", q, 32'h0);
      bus(0, 16'h6000, 0);
      chk("unmapped", q, 32'h0);
      $display("test reset done");
      // fill the whole table; the first status poll must still see pending
      for (i = 0; i < 64; i++) begin
         rnd(r);
         ds[i] = r[2:0];
         bus(1, 16'h6048, {29'h0, ds[i]});
         bus(1, 16'h6044, i);
         bus(0, 16'h6050, 0);
         chk("pend_set", q, 32'h1);
         do bus(0, 16'h6050, 0); while (q[0]);
      end
      // a second command while busy is dropped, so the first index is read
      for (i = 0; i < 8; i++) begin
         j = (i * 9) & 63;
         bus(1, 16'h6044, 32'h80 | j);
         bus(1, 16'h6044, 32'h80 | (j ^ 1));
         do bus(0, 16'h6050, 0); while (q[0]);
         bus(0, 16'h604c, 0);
         chk("table_read", q, {29'h0, ds[j]});
      end
      $display("test table done");
      for (i = 0; i < 40; i++) begin
         rnd(r);
         cfg = (i == 0) ? 18'h3ffff : (i == 1) ? 18'h0 : r[17:0];
         bus(1, 16'h6100, cfg);
         bus(0, 16'h6100, 0);
         chk("cfg", q, cfg);
         chk("cnt_val", o_cnt_rd_val, cfg[6] ? 32'h7ffffffc : 32'h0);
         chk("cnt_test", {31'h0, o_cnt_test}, {31'h0, cfg[6]});
         repeat (20) pkt;
      end
      $display("test packets done");
      // restart mid-run: config returns to its reset value, table entries survive
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      #1 chk("rst_valid", o_res_valid, 32'h0);
      chk("rst_vlan_en", o_res_vlan_en, 32'h0);
      chk("rst_cnt_val", o_cnt_rd_val, 32'h0);
      bus(0, 16'h6100, 0);
      chk("cfg_restart", q, 32'h6);
      bus(1, 16'h6044, 32'h85);
      do bus(0, 16'h6050, 0); while (q[0]);
      bus(0, 16'h604c, 0);
      chk("table_kept", q, {29'h0, ds[5]});
      $display("test restart done");
      wrap_up;
   end
   initial begin
      repeat (30000) @(posedge i_ref_clk);
      n_mismatch++;
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
